//--- hw/ufrs_params.svh
`ifndef UFRS_PARAMS_SVH
`define UFRS_PARAMS_SVH

// Register offsets (byte addresses)
`define UFRS_OFS_ACTION     8'h00
`define UFRS_OFS_STATUS     8'h04
`define UFRS_OFS_CLEAR      8'h08
`define UFRS_OFS_ENABLE     8'h0C
`define UFRS_OFS_STATE      8'h10

// Action register fields
`define UFRS_RESP_MSB       7
`define UFRS_RESP_LSB       6
`define UFRS_RETRY_MSB      5
`define UFRS_RETRY_LSB      3
`define UFRS_DLY_MSB        2
`define UFRS_DLY_LSB        0
`define UFRS_ACTION_RST     8'h00
`define UFRS_RETRY_INF      3'h7

// Event bits of status, clear and enable registers
`define UFRS_EV_FAULT       0
`define UFRS_EV_DISABLE     1
`define UFRS_EV_RESTART     2
`define UFRS_EV_LATCH       3
`define UFRS_EV_RST         4'h0

// Timing
`define UFRS_CLK_MHZ        250
`define UFRS_US_PER_MS      1000
`define UFRS_CYC_PER_MS     (`UFRS_CLK_MHZ * `UFRS_US_PER_MS)

// First delay, ms, per delay code
`define UFRS_D1_0           12'd10
`define UFRS_D1_1           12'd20
`define UFRS_D1_2           12'd40
`define UFRS_D1_3           12'd80
`define UFRS_D1_4           12'd160
`define UFRS_D1_5           12'd320
`define UFRS_D1_6           12'd640
`define UFRS_D1_7           12'd1280

// Second delay, ms, per delay code
`define UFRS_D2_0           12'd252
`define UFRS_D2_1           12'd558
`define UFRS_D2_2           12'd924
`define UFRS_D2_3           12'd1260
`define UFRS_D2_4           12'd1596
`define UFRS_D2_5           12'd1932
`define UFRS_D2_6           12'd2268
`define UFRS_D2_7           12'd2604

`endif

//--- hw/ufrs_pkg.sv
package ufrs_pkg;
`include "ufrs_params.svh"

    typedef enum logic [2:0] {
        ST_RUN,
        ST_DELAY1,
        ST_OFF_WAIT,
        ST_HOLD,
        ST_LATCHED
    } ufrs_state_type;

    typedef struct packed {
        logic [1:0] resp;
        logic [2:0] retry;
        logic [2:0] dly;
    } ufrs_action_type;

    typedef struct packed {
        ufrs_state_type  st;
        ufrs_action_type action;
        logic [3:0]      sts;
        logic [3:0]      ena;
        logic [2:0]      cnt;
        logic [11:0]     timer;
        logic [31:0]     tick;
        logic            restart;
        logic [31:0]     rdata;
    } ufrs_regs_type;

    function automatic logic [11:0] ufrs_dly1_ms(input logic [2:0] code);
        case (code)
            3'h0:    return `UFRS_D1_0;
            3'h1:    return `UFRS_D1_1;
            3'h2:    return `UFRS_D1_2;
            3'h3:    return `UFRS_D1_3;
            3'h4:    return `UFRS_D1_4;
            3'h5:    return `UFRS_D1_5;
            3'h6:    return `UFRS_D1_6;
            default: return `UFRS_D1_7;
        endcase
    endfunction

    function automatic logic [11:0] ufrs_dly2_ms(input logic [2:0] code);
        case (code)
            3'h0:    return `UFRS_D2_0;
            3'h1:    return `UFRS_D2_1;
            3'h2:    return `UFRS_D2_2;
            3'h3:    return `UFRS_D2_3;
            3'h4:    return `UFRS_D2_4;
            3'h5:    return `UFRS_D2_5;
            3'h6:    return `UFRS_D2_6;
            default: return `UFRS_D2_7;
        endcase
    endfunction
endpackage

//--- hw/ufrs_top.sv
// What this block does
// - Response 10 shuts the output down on an undervoltage fault and retries up to the retry field.
// - Response 11 disables the output on a fault and resumes only once the fault has cleared.
// - Retry field codes 000 to 110 give zero to six restart attempts.
// - A fault still present after the last attempt latches the output off, even after the fault clears.
// - The latched-off state is left only on reset, a power-off/power-on cycle or loss of bias.
// - Restart attempts are spaced by the second delay chosen by the delay field.
// - The delay field picks both delays: fault-to-disable (10 ms at 000) and retry gap (252 ms).
// - Response 01 keeps running through the first delay, then acts as retry if the fault remains.
`timescale 1ns/1ps
`include "ufrs_params.svh"

module ufrs_top
    import ufrs_pkg::*;
#(
    parameter int TICK_CYCLES = `UFRS_CYC_PER_MS
) (
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        UV_FAULT,
    input  wire logic        POWER_CYCLE,
    input  wire logic        BIAS_LOST,
    output logic             OUT_EN,
    output logic             RESTART,
    output logic             LATCHED,
    output logic             IRQ
);

    ufrs_regs_type r_r;
    ufrs_regs_type r_nxt;
    logic          ms_tick;
    logic          expired;
    logic          retries_left;
    logic          latch_release;
    logic [3:0]    ev;

    assign ms_tick = (r_r.tick == 32'(TICK_CYCLES - 1));
    assign expired = ms_tick && (r_r.timer == 12'h000);
    // Code 111 is treated as unlimited attempts
    assign retries_left = (r_r.action.retry == `UFRS_RETRY_INF)
                       || (r_r.cnt < r_r.action.retry);
    assign latch_release = POWER_CYCLE || BIAS_LOST;

    always_comb begin
        r_nxt = r_r;
        ev = 4'h0;
        r_nxt.restart = 1'b0;

        // Millisecond time base, restarted whenever a delay is loaded
        if (ms_tick) begin
            r_nxt.tick = 32'h0000_0000;
            if (r_r.timer != 12'h000) begin
                r_nxt.timer = r_r.timer - 12'h001;
            end
        end else begin
            r_nxt.tick = r_r.tick + 32'h0000_0001;
        end

        case (r_r.st)
            ST_RUN: begin
                if (!UV_FAULT) begin
                    r_nxt.cnt = 3'h0;
                end
                if (UV_FAULT && r_r.action.resp != 2'b00) begin
                    ev[`UFRS_EV_FAULT] = 1'b1;
                    r_nxt.tick = 32'h0000_0000;
                    case (r_r.action.resp)
                        2'b01: begin
                            r_nxt.st = ST_DELAY1;
                            r_nxt.timer = ufrs_dly1_ms(r_r.action.dly) - 12'h001;
                        end
                        2'b10: begin
                            ev[`UFRS_EV_DISABLE] = 1'b1;
                            r_nxt.st = ST_OFF_WAIT;
                            r_nxt.timer = ufrs_dly2_ms(r_r.action.dly) - 12'h001;
                        end
                        default: begin
                            ev[`UFRS_EV_DISABLE] = 1'b1;
                            r_nxt.st = ST_HOLD;
                        end
                    endcase
                end
            end
            ST_DELAY1: begin
                // Output stays on while the first delay runs
                if (expired) begin
                    r_nxt.tick = 32'h0000_0000;
                    if (UV_FAULT) begin
                        ev[`UFRS_EV_DISABLE] = 1'b1;
                        r_nxt.st = ST_OFF_WAIT;
                        r_nxt.timer = ufrs_dly2_ms(r_r.action.dly) - 12'h001;
                    end else begin
                        r_nxt.st = ST_RUN;
                        r_nxt.cnt = 3'h0;
                    end
                end
            end
            ST_OFF_WAIT: begin
                if (expired) begin
                    r_nxt.tick = 32'h0000_0000;
                    if (!UV_FAULT) begin
                        // Attempt succeeds: fault is gone, output restarts
                        ev[`UFRS_EV_RESTART] = 1'b1;
                        r_nxt.restart = 1'b1;
                        r_nxt.st = ST_RUN;
                        r_nxt.cnt = 3'h0;
                    end else if (retries_left) begin
                        // Attempt fails: count it and wait another gap
                        ev[`UFRS_EV_RESTART] = 1'b1;
                        r_nxt.restart = 1'b1;
                        r_nxt.cnt = r_r.cnt + 3'h1;
                        r_nxt.timer = ufrs_dly2_ms(r_r.action.dly) - 12'h001;
                    end else begin
                        ev[`UFRS_EV_LATCH] = 1'b1;
                        r_nxt.st = ST_LATCHED;
                    end
                end
            end
            ST_HOLD: begin
                if (!UV_FAULT) begin
                    r_nxt.st = ST_RUN;
                    r_nxt.cnt = 3'h0;
                end
            end
            ST_LATCHED: begin
                // A fault vanishing is not enough; only a power event or reset releases
                if (latch_release) begin
                    r_nxt.st = ST_RUN;
                    r_nxt.cnt = 3'h0;
                end
            end
            default: begin
                r_nxt.st = ST_RUN;
            end
        endcase

        // Register writes
        if (WR) begin
            case (ADDR)
                `UFRS_OFS_ACTION: begin
                    r_nxt.action = ufrs_action_type'(WDATA[7:0]);
                end
                `UFRS_OFS_CLEAR: begin
                    r_nxt.sts = r_r.sts & ~WDATA[3:0];
                end
                `UFRS_OFS_ENABLE: begin
                    r_nxt.ena = WDATA[3:0];
                end
                default: begin
                end
            endcase
        end
        // Events win over a clear in the same cycle
        r_nxt.sts = r_nxt.sts | ev;

        // Read data stands only in the cycle after the strobe
        r_nxt.rdata = 32'h0000_0000;
        if (RD) begin
            case (ADDR)
                `UFRS_OFS_ACTION: r_nxt.rdata = {24'h00_0000, r_r.action};
                `UFRS_OFS_STATUS: r_nxt.rdata = {28'h000_0000, r_r.sts};
                `UFRS_OFS_ENABLE: r_nxt.rdata = {28'h000_0000, r_r.ena};
                `UFRS_OFS_STATE: begin
                    r_nxt.rdata = {24'h00_0000, 2'b00, r_r.cnt, r_r.st};
                end
                default:          r_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            r_r.st      <= ST_RUN;
            r_r.action  <= ufrs_action_type'(`UFRS_ACTION_RST);
            r_r.sts     <= `UFRS_EV_RST;
            r_r.ena     <= `UFRS_EV_RST;
            r_r.cnt     <= 3'h0;
            r_r.timer   <= 12'h000;
            r_r.tick    <= 32'h0000_0000;
            r_r.restart <= 1'b0;
            r_r.rdata   <= 32'h0000_0000;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Output is off while waiting, holding or latched; delay 1 keeps it on
    assign OUT_EN  = (r_r.st == ST_RUN) || (r_r.st == ST_DELAY1);
    assign RESTART = r_r.restart;
    assign LATCHED = (r_r.st == ST_LATCHED);
    assign RDATA   = r_r.rdata;
    assign IRQ     = |(r_r.sts & r_r.ena);

endmodule // ufrs_top

//--- tb/ufrs_top_sva.sv
`timescale 1ns/1ps
module ufrs_top_sva
    import ufrs_pkg::*;
#(
    parameter int TICK_CYCLES = 250000
) (
    input wire logic        CLK_SYS,
    input wire logic        SYS_RST,
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        UV_FAULT,
    input wire logic        POWER_CYCLE,
    input wire logic        BIAS_LOST,
    input wire logic        OUT_EN,
    input wire logic        RESTART,
    input wire logic        LATCHED,
    input wire logic        IRQ
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    a_rdata_slot: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("stray read data");
    a_restart_gap: assert property (RESTART |=> !RESTART [*8]) else $error("restarts too close");
    a_restart_off: assert property (RESTART |-> !$past(OUT_EN)) else $error("restart while on");
    a_latched_off: assert property (LATCHED |-> !OUT_EN) else $error("latched with output on");
    a_latch_hold: assert property (LATCHED && !POWER_CYCLE && !BIAS_LOST && !SYS_RST |=> LATCHED)
        else $error("latched state left early");
    a_latch_free: assert property (LATCHED && (POWER_CYCLE || BIAS_LOST) |=> !LATCHED)
        else $error("latched state not released");
    a_latch_entry: assert property ($rose(LATCHED) |-> !$past(OUT_EN) && $past(UV_FAULT))
        else $error("latched without fault");
    a_off_cause: assert property ($fell(OUT_EN) |-> $past(UV_FAULT))
        else $error("output off without fault");
    a_on_cause: assert property ($rose(OUT_EN) |-> !$past(UV_FAULT) || $past(POWER_CYCLE)
        || $past(BIAS_LOST)) else $error("output back on during fault");
    c_latch: cover property ($rose(LATCHED));
    c_restart: cover property (RESTART);
    c_irq: cover property ($rose(IRQ));
endmodule // ufrs_top_sva

bind ufrs_top ufrs_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.CLK_SYS(CLK_SYS),
    .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .UV_FAULT(UV_FAULT), .POWER_CYCLE(POWER_CYCLE), .BIAS_LOST(BIAS_LOST), .OUT_EN(OUT_EN),
    .RESTART(RESTART), .LATCHED(LATCHED), .IRQ(IRQ));

//--- tb/tb_ufrs_top.sv
`timescale 1ns/1ps
`include "ufrs_params.svh"
module tb_ufrs_top import ufrs_pkg::*;;
    logic        clk_sys, sys_rst, wr, rd, uv_fault, power_cycle, bias_lost;
    logic        out_en, restart, latched, irq, e30, e50;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    int          err_total, n_checks, n, gap;

    ufrs_top #(.TICK_CYCLES(4)) DUT (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .UV_FAULT(uv_fault),
        .POWER_CYCLE(power_cycle), .BIAS_LOST(bias_lost), .OUT_EN(out_en),
        .RESTART(restart), .LATCHED(latched), .IRQ(irq));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk(nm, rdata, exp);
    endtask
    task automatic wait_restart;
        int t;
        t = 0;
        do begin
            step(1);
            t++;
        end while (restart !== 1'b1 && t < 3000);
        if (restart !== 1'b1) begin
            err_total++;
            print_verdict;
        end
    endtask
    // Raises the fault and counts restart pulses until the output latches off
    task automatic run(input logic [7:0] act);
        int t, t1;
        t = 0;
        n = 0;
        wr_reg(`UFRS_OFS_ACTION, {24'h0, act});
        @(posedge clk_sys) uv_fault <= 1'b1;
        while (latched !== 1'b1 && t < 20000) begin
            step(1);
            t++;
            if (t == 30) e30 = out_en;
            if (t == 50) e50 = out_en;
            if (restart === 1'b1) begin
                n++;
                if (n == 1) t1 = t;
                if (n == 2) gap = t - t1;
            end
        end
        if (latched !== 1'b1) begin
            err_total++;
            print_verdict;
        end
        @(posedge clk_sys) uv_fault <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Longest path is the six-retry run, about 16k cycles
    initial begin
        #200000;
        err_total++;
        print_verdict;
    end
    initial begin
        {sys_rst, wr, rd, uv_fault, power_cycle, bias_lost} = 6'b100000;
        addr = 8'h00;
        wdata = 32'h0;
        err_total = 0;
        n_checks = 0;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd_chk("action", `UFRS_OFS_ACTION, 32'h0);
        rd_chk("unmapped", 8'h14, 32'h0);
        rd_chk("clear", `UFRS_OFS_CLEAR, 32'h0);
        wr_reg(`UFRS_OFS_STATUS, 32'hF);
        rd_chk("status", `UFRS_OFS_STATUS, 32'h0);
        @(posedge clk_sys) uv_fault <= 1'b1;
        step(20);
        chk("out_en idle", out_en, 1'b1);
        @(posedge clk_sys) uv_fault <= 1'b0;
        wr_reg(`UFRS_OFS_ENABLE, 32'h8);
        rd_chk("enable", `UFRS_OFS_ENABLE, 32'h8);
        run(8'hB1);
        chk("early off", e30, 1'b0);
        chk("retries", n, 6);
        chk("gap", gap, 558 * 4);
        chk("irq", irq, 1'b1);
        rd_chk("status", `UFRS_OFS_STATUS, 32'hF);
        wr_reg(`UFRS_OFS_CLEAR, 32'hF);
        rd_chk("status", `UFRS_OFS_STATUS, 32'h0);
        chk("irq", irq, 1'b0);
        step(20);
        chk("latched", latched, 1'b1);
        @(posedge clk_sys) power_cycle <= 1'b1;
        @(posedge clk_sys) power_cycle <= 1'b0;
        step(2);
        chk("released", {latched, out_en}, 2'b01);
        run(8'h40);
        chk("retries", n, 0);
        chk("delay1 run", e30, 1'b1);
        chk("delay1 off", e50, 1'b0);
        rd_chk("status", `UFRS_OFS_STATUS, 32'hB);
        wr_reg(`UFRS_OFS_ENABLE, 32'h4);
        #1;
        chk("masked irq", irq, 1'b0);
        @(posedge clk_sys) bias_lost <= 1'b1;
        @(posedge clk_sys) bias_lost <= 1'b0;
        step(2);
        chk("released", {latched, out_en}, 2'b01);
        wr_reg(`UFRS_OFS_ACTION, 32'hC0);
        @(posedge clk_sys) uv_fault <= 1'b1;
        step(40);
        chk("hold off", out_en, 1'b0);
        @(posedge clk_sys) uv_fault <= 1'b0;
        step(3);
        chk("resume", out_en, 1'b1);
        wr_reg(`UFRS_OFS_ACTION, 32'h90);
        @(posedge clk_sys) uv_fault <= 1'b1;
        wait_restart;
        rd_chk("state", `UFRS_OFS_STATE, 32'h0A);
        chk("irq", irq, 1'b1);
        @(posedge clk_sys) uv_fault <= 1'b0;
        wait_restart;
        step(2);
        chk("resume", out_en, 1'b1);
        rd_chk("state", `UFRS_OFS_STATE, 32'h0);
        // Retry 000 latches at the first expiry; then a one-cycle reset must release it
        run(8'h80);
        chk("no retry", n, 0);
        chk("latched", latched, 1'b1);
        @(posedge clk_sys) sys_rst <= 1'b1;
        @(posedge clk_sys) sys_rst <= 1'b0;
        step(1);
        chk("reset release", {latched, out_en}, 2'b01);
        rd_chk("reset status", `UFRS_OFS_STATUS, 32'h0);
        rd_chk("reset state", `UFRS_OFS_STATE, 32'h0);
        rd_chk("reset action", `UFRS_OFS_ACTION, 32'h0);
        print_verdict;
    end
endmodule // tb_ufrs_top
